// *** logic/interrupt_mask_flag_unit.sv ***
// Interrupt enable, flag and vector logic for the CPU sequencer.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "irq_unit_params.svh"


module interrupt_mask_flag_unit
    import irq_unit_pkg::*;
(
    // Clock and reset.
    input  wire logic          ref_clk_i,
    input  wire logic          resetn_i,

    // Register port.
    input  wire logic [5:0]    addr_i,
    input  wire logic [7:0]    wr_data_i,
    input  wire logic          wr_en_i,
    input  wire logic          rd_en_i,
    output logic      [7:0]    rd_data_o,

    // External request pins, sampled as driven.
    input  wire logic          ext_request_zero_i,
    input  wire logic          ext_request_one_i,

    // Timer events and the running timer 1 count.
    input  wire timer_events_t timer_evt_i,
    input  wire logic [15:0]   timer_one_count_i,

    // Sequencer handshake.
    input  wire logic          irq_ack_i,
    output logic               irq_req_o,
    output logic      [3:0]    irq_vector_o,
    output logic               global_enable_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////

    // Register contents.
    logic [7:0]  timer_irq_flags;       // Timer flags.
    logic [7:0]  timer_irq_enables;     // Timer enables.
    logic [7:0]  external_irq_flags;    // External flags.
    logic [7:0]  external_irq_enables;  // External enables.
    logic [7:0]  sense_control;         // Sense fields of both pins.
    logic        global_enable;         // Global interrupt bit.
    logic [15:0] captured_count;        // Count copied at capture.

    // Pin history and trigger results.
    logic [1:0]  ext_pins;              // Current pin levels.
    logic [1:0]  ext_prev;              // Levels one cycle ago.
    logic [1:0]  ext_trig;              // Trigger per pin.

    // Next values and helper terms.
    logic [7:0]  next_timer_flags;      // Timer flags next cycle.
    logic [7:0]  next_ext_flags;        // External flags next cycle.
    logic [7:0]  timer_set;             // Hardware set terms.
    logic [7:0]  timer_clr;             // Clear terms.
    logic [7:0]  ext_set;               // Hardware set terms.
    logic [7:0]  ext_clr;               // Clear terms.
    logic [7:0]  timer_pend;            // Enabled timer flags.
    logic [7:0]  ext_pend;              // Enabled external flags.
    logic [3:0]  next_vector;           // Winning vector.
    logic [7:0]  next_rd_data;          // Read data next cycle.
    logic        ack_taken;             // Entry of a served vector.
    logic        t1_wrap_evt;           // Mode-selected wrap event.

    ////////////////////////////////////////////////////////////////////////
    // Functions.
    ////////////////////////////////////////////////////////////////////////

    // Decides if a pin triggers this cycle under its sense mode.
    function automatic logic pin_trigger(
        input logic [1:0] mode,
        input logic       now,
        input logic       prev
    );
        logic hit;
        hit = 1'b0;
        // Trigger choice.
        // sense field decode
        case (sense_mode_t'(mode))
            SENSE_LOW:      hit = ~now;
            SENSE_RESERVED: hit = 1'b0;
            SENSE_FALL:     hit = prev & ~now;
            SENSE_RISE:     hit = ~prev & now;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Maps a vector to its bit in the timer flag register.
    function automatic logic [7:0] timer_bit_of(input logic [3:0] vec);
        logic [7:0] m;
        m = `RESET_BYTE;
        if (vec == `VEC_CAPTURE)
        begin
            m[`BIT_CAPTURE] = 1'b1;
        end
        else if (vec == `VEC_MATCH_A)
        begin
            m[`BIT_MATCH_A] = 1'b1;
        end
        else if (vec == `VEC_MATCH_B)
        begin
            m[`BIT_MATCH_B] = 1'b1;
        end
        else if (vec == `VEC_T1_WRAP)
        begin
            m[`BIT_T1_WRAP] = 1'b1;
        end
        else if (vec == `VEC_T0_WRAP)
        begin
            m[`BIT_T0_WRAP] = 1'b1;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // External pin triggers.
    ////////////////////////////////////////////////////////////////////////

    // The pins are read straight, whatever their direction.
    // direction ignored
    assign ext_pins = {ext_request_one_i, ext_request_zero_i};

    // Remembers the previous pin levels for edge detection.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ext_prev <= 2'h3;
        end
        else
        begin
            ext_prev <= ext_pins;
        end
    end

    // One trigger decoder per pin, each on its own sense field.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pin
            assign ext_trig[gi] = pin_trigger(sense_control[2*gi+1 -: 2],
                                              ext_pins[gi], ext_prev[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Flag set and clear terms.
    ////////////////////////////////////////////////////////////////////////

    // An entry only counts while a request is shown.
    assign ack_taken = irq_ack_i & irq_req_o;

    // PWM mode flags the turn at bottom, else the plain wrap.
    // bottom turn in PWM
    assign t1_wrap_evt = timer_evt_i.t1_pwm ? timer_evt_i.t1_turn
                                            : timer_evt_i.t1_wrap;

    // Builds the set and clear masks of both flag registers.
    always_comb
    begin
        timer_set = `RESET_BYTE;
        ext_set   = `RESET_BYTE;
        timer_set[`BIT_T1_WRAP] = t1_wrap_evt;
        timer_set[`BIT_MATCH_A] = timer_evt_i.match_a;
        timer_set[`BIT_MATCH_B] = timer_evt_i.match_b;
        timer_set[`BIT_CAPTURE] = timer_evt_i.capture;
        timer_set[`BIT_T0_WRAP] = timer_evt_i.t0_wrap;
        ext_set[`BIT_EXT_ONE]  = ext_trig[1];
        ext_set[`BIT_EXT_ZERO] = ext_trig[0];

        timer_clr = `RESET_BYTE;
        if (wr_en_i && addr_i == `OFS_TIMER_IRQ_FLAGS)
        begin
            timer_clr = wr_data_i;
        end
        if (ack_taken)
        begin
            timer_clr = timer_clr | timer_bit_of(irq_vector_o);
        end

        ext_clr = `RESET_BYTE;
        if (wr_en_i && addr_i == `OFS_EXT_IRQ_FLAGS)
        begin
            ext_clr = wr_data_i;
        end
        if (ack_taken && irq_vector_o == `VEC_EXT_ZERO)
        begin
            ext_clr[`BIT_EXT_ZERO] = 1'b1;
        end
        if (ack_taken && irq_vector_o == `VEC_EXT_ONE)
        begin
            ext_clr[`BIT_EXT_ONE] = 1'b1;
        end

        // A new event beats a clear in the same cycle.
        // unused bits held zero
        next_timer_flags = ((timer_irq_flags & ~timer_clr) | timer_set)
                           & `TIMER_BITS_MASK;
        next_ext_flags   = ((external_irq_flags & ~ext_clr) | ext_set)
                           & `EXT_BITS_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag registers.
    ////////////////////////////////////////////////////////////////////////

    // Timer flags.
    // timer flags reset zero
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            timer_irq_flags <= `RESET_BYTE;
        end
        else
        begin
            timer_irq_flags <= next_timer_flags;
        end
    end

    // External flags.
    // external flags reset zero
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            external_irq_flags <= `RESET_BYTE;
        end
        else
        begin
            external_irq_flags <= next_ext_flags;
        end
    end

    // Copies the timer count in the cycle its flag is set.
    // capture copy with flag
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            captured_count <= `RESET_COUNT;
        end
        else if (timer_evt_i.capture)
        begin
            captured_count <= timer_one_count_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable and control registers.
    ////////////////////////////////////////////////////////////////////////

    // Software-written enables and sense fields.
    // timer enable layout
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            timer_irq_enables    <= `RESET_BYTE;
            external_irq_enables <= `RESET_BYTE;
            sense_control        <= `RESET_BYTE;
        end
        else if (wr_en_i)
        begin
            // Address decode of the writable control bytes.
            if (addr_i == `OFS_TIMER_IRQ_ENABLES)
            begin
                timer_irq_enables <= wr_data_i & `TIMER_BITS_MASK;
            end
            else if (addr_i == `OFS_EXT_IRQ_ENABLES)
            begin
                external_irq_enables <= wr_data_i & `EXT_BITS_MASK;
            end
            else if (addr_i == `OFS_SENSE_CONTROL)
            begin
                sense_control <= wr_data_i & `SENSE_BITS_MASK;
            end
        end
    end

    // Global bit: a software write wins over an entry clear.
    // entry clears global bit
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            global_enable <= 1'b0;
        end
        else if (wr_en_i && addr_i == `OFS_STATUS_WORD)
        begin
            global_enable <= wr_data_i[`BIT_GLOBAL];
        end
        else if (ack_taken)
        begin
            global_enable <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request arbitration.
    ////////////////////////////////////////////////////////////////////////

    // A source pends only when its flag and enable are both one.
    // flag and enable
    assign timer_pend = timer_irq_flags & timer_irq_enables;
    assign ext_pend   = external_irq_flags & external_irq_enables;

    // Picks the lowest vector address among pending sources.
    // lowest vector first
    always_comb
    begin
        if (ext_pend[`BIT_EXT_ZERO])
        begin
            next_vector = `VEC_EXT_ZERO;
        end
        else if (ext_pend[`BIT_EXT_ONE])
        begin
            next_vector = `VEC_EXT_ONE;
        end
        else if (timer_pend[`BIT_CAPTURE])
        begin
            next_vector = `VEC_CAPTURE;
        end
        else if (timer_pend[`BIT_MATCH_A])
        begin
            next_vector = `VEC_MATCH_A;
        end
        else if (timer_pend[`BIT_MATCH_B])
        begin
            next_vector = `VEC_MATCH_B;
        end
        else if (timer_pend[`BIT_T1_WRAP])
        begin
            next_vector = `VEC_T1_WRAP;
        end
        else if (timer_pend[`BIT_T0_WRAP])
        begin
            next_vector = `VEC_T0_WRAP;
        end
        else
        begin
            next_vector = `VEC_NONE;
        end
    end

    // Registered request; dropped in the entry cycle so that the
    // just-cleared flag is never offered twice.
    // global bit gates
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= `VEC_NONE;
        end
        else if (ack_taken)
        begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= `VEC_NONE;
        end
        else
        begin
            irq_req_o    <= global_enable && (next_vector != `VEC_NONE);
            irq_vector_o <= global_enable ? next_vector : `VEC_NONE;
        end
    end

    // Mirror of the global bit for the core.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            global_enable_o <= 1'b0;
        end
        else
        begin
            global_enable_o <= global_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////////////

    // Read decode; unmapped addresses read zero.
    // reserved bits read zero
    always_comb
    begin
        next_rd_data = `RESET_BYTE;
        if (addr_i == `OFS_TIMER_IRQ_FLAGS)
        begin
            next_rd_data = timer_irq_flags;
        end
        else if (addr_i == `OFS_TIMER_IRQ_ENABLES)
        begin
            next_rd_data = timer_irq_enables;
        end
        else if (addr_i == `OFS_EXT_IRQ_FLAGS)
        begin
            next_rd_data = external_irq_flags;
        end
        else if (addr_i == `OFS_EXT_IRQ_ENABLES)
        begin
            next_rd_data = external_irq_enables;
        end
        else if (addr_i == `OFS_SENSE_CONTROL)
        begin
            next_rd_data = sense_control;
        end
        else if (addr_i == `OFS_STATUS_WORD)
        begin
            next_rd_data[`BIT_GLOBAL] = global_enable;
        end
        else if (addr_i == `OFS_CAPTURE_LOW)
        begin
            next_rd_data = captured_count[7:0];
        end
        else if (addr_i == `OFS_CAPTURE_HIGH)
        begin
            next_rd_data = captured_count[15:8];
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_data_o <= `RESET_BYTE;
        end
        else if (rd_en_i)
        begin
            rd_data_o <= next_rd_data;
        end
        else
        begin
            rd_data_o <= `RESET_BYTE;
        end
    end

endmodule

// *** logic/irq_unit_params.svh ***
// Offsets, bit positions, reset values and vectors of the interrupt unit.
`ifndef IRQ_UNIT_PARAMS_SVH
`define IRQ_UNIT_PARAMS_SVH

// Register offsets in the 64-byte I/O space.
`define OFS_TIMER_IRQ_FLAGS     6'h38
`define OFS_TIMER_IRQ_ENABLES   6'h39
`define OFS_EXT_IRQ_FLAGS       6'h3A
`define OFS_EXT_IRQ_ENABLES     6'h3B
`define OFS_SENSE_CONTROL       6'h35
`define OFS_STATUS_WORD         6'h3F
`define OFS_CAPTURE_LOW         6'h24
`define OFS_CAPTURE_HIGH        6'h25

// Bit positions in the timer registers.
`define BIT_T1_WRAP             7
`define BIT_MATCH_A             6
`define BIT_MATCH_B             5
`define BIT_CAPTURE             3
`define BIT_T0_WRAP             1

// Bit positions in the external registers and the status word.
`define BIT_EXT_ONE             7
`define BIT_EXT_ZERO            6
`define BIT_GLOBAL              7

// Implemented bits; all others read zero.
`define TIMER_BITS_MASK         8'hEA
`define EXT_BITS_MASK           8'hC0
`define SENSE_BITS_MASK         8'h0F

// Reset values.
`define RESET_BYTE              8'h00
`define RESET_COUNT             16'h0000

// Vector addresses, lowest served first.
`define VEC_NONE                4'h0
`define VEC_EXT_ZERO            4'h1
`define VEC_EXT_ONE             4'h2
`define VEC_CAPTURE             4'h3
`define VEC_MATCH_A             4'h4
`define VEC_MATCH_B             4'h5
`define VEC_T1_WRAP             4'h6
`define VEC_T0_WRAP             4'h8

`endif

// *** logic/irq_unit_pkg.sv ***
// Types shared by the interrupt mask and flag unit.
package irq_unit_pkg;

    // Trigger selected by a two-bit sense control field.
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_RESERVED,
        SENSE_FALL,
        SENSE_RISE
    } sense_mode_t;

    // One-cycle event pulses from the timer units, plus the timer 1 PWM mode level.
    typedef struct packed {
        logic t1_wrap;
        logic t1_turn;
        logic t1_pwm;
        logic match_a;
        logic match_b;
        logic capture;
        logic t0_wrap;
    } timer_events_t;

endpackage

// *** tb/irq_unit_checker.sv ***
// Port-level checks for the interrupt mask and flag unit.
`timescale 1ns/1ps
`include "irq_unit_params.svh"

////////////////////////////////////////////////////////////////
module irq_unit_checker
    import irq_unit_pkg::*;
(
    // Clock and reset.
    input  wire logic          ref_clk_i,
    input  wire logic          resetn_i,
    // Register port.
    input  wire logic [5:0]    addr_i,
    input  wire logic [7:0]    wr_data_i,
    input  wire logic          wr_en_i,
    input  wire logic          rd_en_i,
    input  wire logic [7:0]    rd_data_o,
    // Pins and timer events.
    input  wire logic          ext_request_zero_i,
    input  wire logic          ext_request_one_i,
    input  wire timer_events_t timer_evt_i,
    input  wire logic [15:0]   timer_one_count_i,
    // Sequencer handshake.
    input  wire logic          irq_ack_i,
    input  wire logic          irq_req_o,
    input  wire logic [3:0]    irq_vector_o,
    input  wire logic          global_enable_o
);
    // All checks share the one clock and pause in reset.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_ack_drops_req: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
        else $error("request stayed up after vector entry");
    a_ack_clears_global: assert property (irq_req_o && irq_ack_i
        && !(wr_en_i && addr_i == `OFS_STATUS_WORD) |-> ##2 !global_enable_o)
        else $error("global bit survived vector entry");
    a_req_has_global: assert property (irq_req_o && $past(irq_req_o) |-> global_enable_o)
        else $error("request standing without global bit");
    a_req_holds: assert property (irq_req_o && !irq_ack_i && !wr_en_i |=> irq_req_o)
        else $error("request dropped without entry or write");
    a_idle_vector: assert property (!irq_req_o |-> irq_vector_o == `VEC_NONE)
        else $error("vector shown with no request");
    a_vector_legal: assert property (irq_req_o |-> irq_vector_o inside {`VEC_EXT_ZERO, `VEC_EXT_ONE,
        `VEC_CAPTURE, `VEC_MATCH_A, `VEC_MATCH_B, `VEC_T1_WRAP, `VEC_T0_WRAP})
        else $error("vector outside the served set");
    a_timer_resv_zero: assert property ($past(rd_en_i) && ($past(addr_i) inside {`OFS_TIMER_IRQ_FLAGS,
        `OFS_TIMER_IRQ_ENABLES}) |-> (rd_data_o & ~`TIMER_BITS_MASK) == 8'h00)
        else $error("reserved timer bit read as one");
    a_ext_resv_zero: assert property ($past(rd_en_i) && ($past(addr_i) inside {`OFS_EXT_IRQ_FLAGS,
        `OFS_EXT_IRQ_ENABLES}) |-> (rd_data_o & ~`EXT_BITS_MASK) == 8'h00)
        else $error("reserved external bit read as one");
    a_read_one_cycle: assert property (rd_data_o != 8'h00 |-> $past(rd_en_i))
        else $error("read data outside its cycle");
endmodule

bind interrupt_mask_flag_unit irq_unit_checker u_chk (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .ext_request_zero_i(ext_request_zero_i), .ext_request_one_i(ext_request_one_i),
    .timer_evt_i(timer_evt_i), .timer_one_count_i(timer_one_count_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .global_enable_o(global_enable_o)
);

// *** tb/seq_model.sv ***
// Sequencer model that enters a vector after a chosen wait.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
module seq_model
(
    // Clock and reset.
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    // Request side.
    input  wire logic       irq_req_i,
    input  wire logic [1:0] delay_i,
    output logic            irq_ack_o
);
    logic [1:0] wait_cnt; // Cycles waited on the standing request.

    // One ack per request, dropped at the edge that takes it.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_cnt  <= 2'h0;
            irq_ack_o <= 1'b0;
        end
        else if (irq_ack_o || !irq_req_i)
        begin
            wait_cnt  <= 2'h0;
            irq_ack_o <= 1'b0;
        end
        else if (wait_cnt >= delay_i)
        begin
            irq_ack_o <= 1'b1;
        end
        else
        begin
            wait_cnt  <= wait_cnt + 2'h1;
        end
    end
endmodule

// *** tb/interrupt_mask_flag_unit_tb.sv ***
// Self-checking bench for the interrupt mask and flag unit.
`timescale 1ns/1ps
`include "irq_unit_params.svh"

////////////////////////////////////////////////////////////////
module interrupt_mask_flag_unit_tb
    import irq_unit_pkg::*;
;
    logic          clk     = 1'b0;  // Bench clock.
    logic          rst_n   = 1'b0;  // Reset, low active.
    logic [5:0]    addr    = 6'h00; // Register address.
    logic [7:0]    wdata   = 8'h00; // Write data.
    logic          wr_en   = 1'b0;  // Write strobe.
    logic          rd_en   = 1'b0;  // Read strobe.
    logic [1:0]    pins    = 2'h3;  // Pin levels, idle high.
    timer_events_t evt     = '0;    // Timer event pulses.
    logic [15:0]   count   = 16'h0000; // Timer 1 count.
    logic [1:0]    delay   = 2'h0;  // Sequencer wait.
    logic          pwm     = 1'b0;  // Timer 1 in PWM mode.
    logic [7:0]    rd_data;         // Read data seen.
    logic          ack;             // Vector entry.
    logic          req;             // Request standing.
    logic [3:0]    vec;             // Vector shown.
    logic          gen;             // Global copy.
    logic          rd_seen = 1'b0;  // Read launched last edge.
    logic [15:0]   cnt_v;           // Count handed to the unit.
    logic [7:0]    exp_rd[$];       // Expected read data.
    logic [3:0]    exp_vec[$];      // Expected vectors.
    int            mismatches = 0;
    int            cmp_count  = 0;
    int            seed;
    localparam logic [5:0] ofs_tab [5] = '{`OFS_TIMER_IRQ_FLAGS, `OFS_TIMER_IRQ_ENABLES,
        `OFS_EXT_IRQ_FLAGS, `OFS_EXT_IRQ_ENABLES, 6'h00};
    localparam logic [6:0] ev_tab [5] = '{7'h40, 7'h08, 7'h04, 7'h02, 7'h01};
    localparam logic [7:0] fl_tab [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02};
    localparam logic [3:0] pri_tab [5] = '{`VEC_CAPTURE, `VEC_MATCH_A, `VEC_MATCH_B, `VEC_T1_WRAP, `VEC_T0_WRAP};

    initial forever #5 clk = ~clk;

    interrupt_mask_flag_unit DUT (
        .ref_clk_i(clk), .resetn_i(rst_n), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .rd_data_o(rd_data), .ext_request_zero_i(pins[0]), .ext_request_one_i(pins[1]),
        .timer_evt_i(evt), .timer_one_count_i(count), .irq_ack_i(ack), .irq_req_o(req),
        .irq_vector_o(vec), .global_enable_o(gen)
    );

    seq_model u_seq (.ref_clk_i(clk), .resetn_i(rst_n), .irq_req_i(req), .delay_i(delay), .irq_ack_o(ack));

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // One-cycle register read; the monitor checks the data.
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_rd.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // One-cycle timer event pulse, the PWM level kept.
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        evt <= timer_events_t'(v | {2'b00, pwm, 4'h0});
        @(posedge clk);
        evt <= timer_events_t'({2'b00, pwm, 4'h0});
    endtask

    // Sets the global bit and waits for the sequencer to enter a vector.
    task automatic take(input logic [3:0] v);
        int n;
        n = 0;
        exp_vec.push_back(v);
        delay <= 2'($random(seed));
        wr(`OFS_STATUS_WORD, 8'h80);
        while (exp_vec.size() != 0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (exp_vec.size() != 0)
        begin
            mismatches++;
            $display("[FAIL] vector wait expected %h seen none", v);
            print_verdict();
        end
    endtask

    // Monitor: read data one cycle after the strobe, vectors at entry.
    always @(posedge clk)
    begin
        if (rd_seen)
            chk("read data", exp_rd.pop_front(), rd_data);
        rd_seen = rd_en;
        if (req && ack)
            chk("vector", {4'h0, exp_vec.pop_front()}, {4'h0, vec});
    end

    initial
    begin
        seed = 32'h855a_f11d;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ofs_tab[i]) rd(ofs_tab[i], 8'h00);
        wr(`OFS_TIMER_IRQ_ENABLES, 8'hFF);
        rd(`OFS_TIMER_IRQ_ENABLES, 8'hEA);
        wr(`OFS_EXT_IRQ_ENABLES, 8'hFF);
        rd(`OFS_EXT_IRQ_ENABLES, 8'hC0);
        wr(`OFS_TIMER_IRQ_ENABLES, 8'h00);
        wr(`OFS_EXT_IRQ_ENABLES, 8'h00);
        // Each timer event alone: flag bit, capture copy, write-one clear.
        for (int k = 0; k < 5; k++)
        begin
            cnt_v = 16'($random(seed));
            count <= cnt_v;
            pulse(ev_tab[k]);
            rd(`OFS_TIMER_IRQ_FLAGS, fl_tab[k]);
            if (ev_tab[k][1])
            begin
                rd(`OFS_CAPTURE_LOW, cnt_v[7:0]);
                rd(`OFS_CAPTURE_HIGH, cnt_v[15:8]);
            end
            wr(`OFS_TIMER_IRQ_FLAGS, fl_tab[k]);
            rd(`OFS_TIMER_IRQ_FLAGS, 8'h00);
        end
        // In PWM the direction turn sets the wrap flag, the wrap does not.
        pwm <= 1'b1;
        pulse(7'h40);
        rd(`OFS_TIMER_IRQ_FLAGS, 8'h00);
        pulse(7'h20);
        rd(`OFS_TIMER_IRQ_FLAGS, 8'h80);
        wr(`OFS_TIMER_IRQ_FLAGS, 8'h80);
        pwm <= 1'b0;
        pulse(7'h20);
        rd(`OFS_TIMER_IRQ_FLAGS, 8'h00);
        // All timer requests at once, served lowest vector first.
        wr(`OFS_TIMER_IRQ_ENABLES, 8'hEA);
        pulse(7'h4F);
        rd(`OFS_TIMER_IRQ_FLAGS, 8'hEA);
        chk("request without global", 8'h00, {7'h00, req});
        foreach (pri_tab[k]) take(pri_tab[k]);
        rd(`OFS_TIMER_IRQ_FLAGS, 8'h00);
        rd(`OFS_STATUS_WORD, 8'h00);
        chk("global copy", 8'h00, {7'h00, gen});
        wr(`OFS_TIMER_IRQ_ENABLES, 8'h00);
        // Every sense mode on both pins.
        for (int p = 0; p < 2; p++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                pins[p] <= (m != 3);
                wr(`OFS_SENSE_CONTROL, 8'(m << (2 * p)));
                wr(`OFS_EXT_IRQ_FLAGS, 8'hC0);
                pins[p] <= (m == 3);
                wr(`OFS_EXT_IRQ_FLAGS, 8'h00);
                rd(`OFS_EXT_IRQ_FLAGS, (m == 1) ? 8'h00 : (p ? 8'h80 : 8'h40));
                if (m == 0)
                begin
                    wr(`OFS_EXT_IRQ_FLAGS, 8'hC0);
                    rd(`OFS_EXT_IRQ_FLAGS, p ? 8'h80 : 8'h40);
                end
            end
        end
        // Pin requests taken through the sequencer, flag cleared on entry.
        wr(`OFS_SENSE_CONTROL, 8'h0A);
        wr(`OFS_EXT_IRQ_ENABLES, 8'hC0);
        wr(`OFS_EXT_IRQ_FLAGS, 8'hC0);
        for (int p = 0; p < 2; p++)
        begin
            pins <= p ? 2'h1 : 2'h2;
            take(p ? `VEC_EXT_ONE : `VEC_EXT_ZERO);
            rd(`OFS_EXT_IRQ_FLAGS, 8'h00);
        end
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule
